/* design/tpio_params.svh */
// Constants for the terminal peripheral I/O decode block
`ifndef TPIO_PARAMS_SVH
`define TPIO_PARAMS_SVH

// =====================================================================
// Port address map
`define TPIO_SCE_BASE       8'h20
`define TPIO_SCE_LAST       8'h26
`define TPIO_BAUD_PORT      8'h28
`define TPIO_ADC_HI_NIBBLE  4'h3

// =====================================================================
// Interrupt entry layout
`define TPIO_VEC_BASE       16'h0010
`define TPIO_VEC_SPACING    16'h0008
`define TPIO_VEC_RESERVED   16'h0010

// =====================================================================
// Timing
`define TPIO_REF_CLK_KHZ    100000
`define TPIO_ADC_CLK_KHZ    780
`define TPIO_ADC_HALF_CYC   (`TPIO_REF_CLK_KHZ / (2 * `TPIO_ADC_CLK_KHZ))
`define TPIO_CONV_TIME_US   100
`define TPIO_START_CYC      4
`define TPIO_DATA_SETTLE    3

// =====================================================================
// Reset values
`define TPIO_DISP_ADDR_RST  12'h000

`endif

/* design/tpio_pkg.sv */
// Types for the terminal peripheral I/O decode block
package tpio_pkg;

  // =====================================================================
  // Converter sequencer
  typedef enum logic [2:0] {
    TPIO_ADC_IDLE,
    TPIO_ADC_START,
    TPIO_ADC_WAIT_LOW,
    TPIO_ADC_WAIT_EOC,
    TPIO_ADC_SETTLE
  } tpio_adc_state_t;

endpackage

/* design/tpio_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps

module tpio_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  // =====================================================================
  // Second stage only reads the first
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule // tpio_sync

/* design/tpio_decode.sv */
// Peripheral port decode and converter control for the display terminal
`timescale 1ns/1ps
`include "tpio_params.svh"

module tpio_decode
  import tpio_pkg::*;
#(
  parameter logic [15:0] ADC_IRQ_INDEX = 16'h0004,
  parameter int          ADDR_W        = 12
) (
  input  wire logic              REF_CLK,
  input  wire logic              SYS_RST,
  input  wire logic [7:0]        IO_ADDR,
  input  wire logic              IO_RD,
  input  wire logic              IO_WR,
  output logic      [7:0]        IO_RDATA,
  output logic                   IO_RVALID,
  output logic                   SCE_SEL,
  output logic      [2:0]        SCE_REG,
  output logic                   SCE_RD,
  output logic                   SCE_WR,
  output logic                   BAUD_SEL,
  input  wire logic [3:0]        BAUD_SW,
  output logic                   ADC_SEL,
  output logic                   ADC_CLK,
  output logic                   ADC_START,
  output logic                   ADC_ALE,
  output logic      [2:0]        ADC_CHAN,
  output logic                   ADC_OE,
  input  wire logic              ADC_EOC,
  input  wire logic [7:0]        ADC_DATA,
  output logic                   ADC_IRQ,
  output logic      [15:0]       ADC_IRQ_VECTOR,
  output logic                   ADC_BUSY,
  input  wire logic              ROW_END,
  input  wire logic              DISP_ADV,
  input  wire logic              ROW_START_LD,
  input  wire logic [ADDR_W-1:0] ROW_START_VAL,
  output logic      [ADDR_W-1:0] DISP_ADDR
);

  localparam logic [6:0] HALF_CYC = 7'(`TPIO_ADC_HALF_CYC);

  logic [12:0]     sync_in;
  logic [12:0]     sync_q;
  logic            eoc_s;
  logic [7:0]      adc_data_s;
  logic [3:0]      baud_s;
  logic            eoc_d_ff;
  logic            access;
  logic            hit_sce;
  logic            hit_baud;
  logic            hit_adc;
  logic [6:0]      div_ff;
  logic            adc_clk_ff;
  tpio_adc_state_t state_ff;
  logic [2:0]      cnt_ff;
  logic [7:0]      result_ff;
  logic            row_ld_ff;
  logic [ADDR_W-1:0] row_val_ff;

  // =====================================================================
  // Pin input synchronisers
  assign sync_in = {ADC_EOC, ADC_DATA, BAUD_SW};

  tpio_sync #(
    .WIDTH (13)
  ) u_sync (
    .clk      (REF_CLK),
    .rst      (SYS_RST),
    .async_in (sync_in),
    .sync_out (sync_q)
  );

  assign eoc_s      = sync_q[12];
  assign adc_data_s = sync_q[11:4];
  assign baud_s     = sync_q[3:0];

  // =====================================================================
  // Address decode
  assign access   = IO_RD ^ IO_WR;
  assign hit_sce  = (IO_ADDR >= `TPIO_SCE_BASE) && (IO_ADDR <= `TPIO_SCE_LAST);
  assign hit_baud = (IO_ADDR == `TPIO_BAUD_PORT);
  assign hit_adc  = (IO_ADDR[7:4] == `TPIO_ADC_HI_NIBBLE) && !IO_ADDR[3];

  // Select strobes, one-cycle, at most one per access
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      SCE_SEL  <= 1'b0;
      SCE_REG  <= 3'h0;
      SCE_RD   <= 1'b0;
      SCE_WR   <= 1'b0;
      BAUD_SEL <= 1'b0;
      ADC_SEL  <= 1'b0;
    end else begin
      SCE_SEL  <= access && hit_sce;
      SCE_REG  <= IO_ADDR[2:0];
      SCE_RD   <= IO_RD && !IO_WR && hit_sce;
      SCE_WR   <= IO_WR && !IO_RD && hit_sce;
      BAUD_SEL <= access && hit_baud;
      ADC_SEL  <= access && hit_adc;
    end
  end

  // =====================================================================
  // Read data return
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      IO_RDATA  <= 8'h00;
      IO_RVALID <= 1'b0;
    end else begin
      IO_RVALID <= 1'b0;
      IO_RDATA  <= 8'h00;
      if (IO_RD && !IO_WR && hit_baud) begin
        IO_RDATA  <= {4'h0, baud_s};
        IO_RVALID <= 1'b1;
      end else if (IO_RD && !IO_WR && hit_adc) begin
        IO_RDATA  <= result_ff;
        IO_RVALID <= 1'b1;
      end
    end
  end

  // =====================================================================
  // Converter clock divider
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      div_ff     <= 7'h00;
      adc_clk_ff <= 1'b0;
    end else if (div_ff == HALF_CYC - 7'h01) begin
      div_ff     <= 7'h00;
      adc_clk_ff <= !adc_clk_ff;
    end else begin
      div_ff     <= div_ff + 7'h01;
    end
  end

  assign ADC_CLK = adc_clk_ff;

  // =====================================================================
  // Converter sequencer
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_ff  <= TPIO_ADC_IDLE;
      cnt_ff    <= 3'h0;
      ADC_START <= 1'b0;
      ADC_ALE   <= 1'b0;
      ADC_CHAN  <= 3'h0;
      ADC_OE    <= 1'b0;
      ADC_BUSY  <= 1'b0;
      result_ff <= 8'h00;
    end else begin
      case (state_ff)
        TPIO_ADC_IDLE: begin
          if (IO_WR && !IO_RD && hit_adc) begin
            ADC_CHAN  <= IO_ADDR[2:0];
            ADC_ALE   <= 1'b1;
            ADC_START <= 1'b1;
            ADC_OE    <= 1'b0;
            ADC_BUSY  <= 1'b1;
            cnt_ff    <= 3'h0;
            state_ff  <= TPIO_ADC_START;
          end
        end
        TPIO_ADC_START: begin
          cnt_ff <= cnt_ff + 3'h1;
          if (cnt_ff == 3'(`TPIO_START_CYC - 1)) begin
            ADC_ALE   <= 1'b0;
            ADC_START <= 1'b0;
            state_ff  <= TPIO_ADC_WAIT_LOW;
          end
        end
        TPIO_ADC_WAIT_LOW: begin
          if (!eoc_s) begin
            state_ff <= TPIO_ADC_WAIT_EOC;
          end
        end
        TPIO_ADC_WAIT_EOC: begin
          if (eoc_s) begin
            ADC_OE   <= 1'b1;
            cnt_ff   <= 3'h0;
            state_ff <= TPIO_ADC_SETTLE;
          end
        end
        TPIO_ADC_SETTLE: begin
          cnt_ff <= cnt_ff + 3'h1;
          if (cnt_ff == 3'(`TPIO_DATA_SETTLE)) begin
            result_ff <= adc_data_s;
            ADC_BUSY  <= 1'b0;
            state_ff  <= TPIO_ADC_IDLE;
          end
        end
        default: begin
          state_ff <= TPIO_ADC_IDLE;
        end
      endcase
    end
  end

  // =====================================================================
  // Completion interrupt, set wins over clear by read
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      eoc_d_ff <= 1'b0;
      ADC_IRQ  <= 1'b0;
    end else begin
      eoc_d_ff <= ADC_BUSY;
      if (eoc_d_ff && !ADC_BUSY) begin
        ADC_IRQ <= 1'b1;
      end else if (IO_RD && !IO_WR && hit_adc) begin
        ADC_IRQ <= 1'b0;
      end
    end
  end

  // Entry point for the converter interrupt
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ADC_IRQ_VECTOR <= `TPIO_VEC_BASE;
    end else begin
      ADC_IRQ_VECTOR <= 16'(`TPIO_VEC_BASE + ADC_IRQ_INDEX * `TPIO_VEC_SPACING);
    end
  end

  // =====================================================================
  // Display row start address
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      row_ld_ff  <= 1'b0;
      row_val_ff <= '0;
      DISP_ADDR  <= ADDR_W'(`TPIO_DISP_ADDR_RST);
    end else begin
      if (ROW_START_LD) begin
        row_ld_ff  <= 1'b1;
        row_val_ff <= ROW_START_VAL;
      end else if (ROW_END) begin
        row_ld_ff  <= 1'b0;
      end
      if (ROW_END) begin
        DISP_ADDR <= row_ld_ff ? row_val_ff : DISP_ADDR + 1'b1;
      end else if (DISP_ADV) begin
        DISP_ADDR <= DISP_ADDR + 1'b1;
      end
    end
  end

endmodule // tpio_decode

/* tb/tpio_decode_chk.sv */
// Port-level checker for the peripheral decode block
`timescale 1ns/1ps

module tpio_decode_chk #(
  parameter logic [15:0] ADC_IRQ_INDEX = 16'h0004
) (
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  input wire logic [7:0]  IO_ADDR,
  input wire logic        IO_RD,
  input wire logic        IO_WR,
  input wire logic        IO_RVALID,
  input wire logic        SCE_SEL,
  input wire logic [2:0]  SCE_REG,
  input wire logic        SCE_RD,
  input wire logic        BAUD_SEL,
  input wire logic        ADC_SEL,
  input wire logic        ADC_START,
  input wire logic [2:0]  ADC_CHAN,
  input wire logic        ADC_BUSY,
  input wire logic [15:0] ADC_IRQ_VECTOR
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  logic acc, rd, wr, sce, adc, bd;
  assign acc = IO_RD ^ IO_WR;
  assign rd  = IO_RD && !IO_WR;
  assign wr  = IO_WR && !IO_RD;
  assign sce = IO_ADDR >= 8'h20 && IO_ADDR <= 8'h26;
  assign adc = IO_ADDR[7:3] == 5'h06;
  assign bd  = IO_ADDR == 8'h28;
  // =====================================================================
  // Decode
  a_sce_read: assert property (rd && sce |=> SCE_SEL && SCE_RD)
    else $error("serial read not selected");
  a_sce_regsel: assert property (acc && sce |=> SCE_REG == $past(IO_ADDR[2:0]))
    else $error("serial register select wrong");
  a_baud_read: assert property (rd && bd |=> BAUD_SEL && IO_RVALID)
    else $error("switch read missing");
  a_adc_read: assert property (rd && adc |=> ADC_SEL && IO_RVALID)
    else $error("converter read missing");
  a_no_stray: assert property (acc && !sce && !adc && !bd |=> !(SCE_SEL || BAUD_SEL || ADC_SEL))
    else $error("stray select");
  a_one_sel: assert property (acc && (sce || adc || bd) |=> $onehot({SCE_SEL, BAUD_SEL, ADC_SEL}))
    else $error("not exactly one select");
  // =====================================================================
  // Converter
  a_adc_start: assert property (wr && adc && !ADC_BUSY |=>
    ADC_START && ADC_BUSY && ADC_CHAN == $past(IO_ADDR[2:0]))
    else $error("conversion not started");
  a_busy_keep: assert property (wr && adc && ADC_BUSY |=> ADC_SEL && $stable(ADC_CHAN))
    else $error("channel changed while busy");
  a_start_len: assert property ($rose(ADC_START) |-> ADC_START[*4] ##1 !ADC_START)
    else $error("start pulse length wrong");
  a_vec_place: assert property (!$past(SYS_RST) |->
    ADC_IRQ_VECTOR == 16'h0010 + 16'h0008 * ADC_IRQ_INDEX)
    else $error("interrupt entry misplaced");
endmodule // tpio_decode_chk

bind tpio_decode tpio_decode_chk #(.ADC_IRQ_INDEX(ADC_IRQ_INDEX)) i_tpio_decode_chk (
  .REF_CLK, .SYS_RST, .IO_ADDR, .IO_RD, .IO_WR, .IO_RVALID, .SCE_SEL, .SCE_REG,
  .SCE_RD, .BAUD_SEL, .ADC_SEL, .ADC_START, .ADC_CHAN, .ADC_BUSY, .ADC_IRQ_VECTOR);

/* tb/tpio_adc_model.sv */
// Behavioural model of the external converter
`timescale 1ns/1ps

module tpio_adc_model #(
  parameter int CONV = 300
) (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic       oe,
  input  wire logic [7:0] val,
  output logic            eoc,
  output logic      [7:0] data
);
  int   cnt_ff = 0;
  logic start_d_ff = 1'b0;
  // =====================================================================
  // Conversion timer
  always_ff @(posedge clk) begin
    start_d_ff <= start;
    if (start && !start_d_ff) cnt_ff <= CONV;
    else if (cnt_ff > 0) cnt_ff <= cnt_ff - 1;
  end
  assign eoc  = cnt_ff == 0;
  // Released bus shows inverted value
  assign data = oe ? val : ~val;
endmodule // tpio_adc_model

/* tb/tpio_decode_test.sv */
// Self-checking testbench for the peripheral decode block
`timescale 1ns/1ps

module tpio_decode_test;
  logic        REF_CLK = 1'b0, SYS_RST = 1'b1, IO_RD = 1'b0, IO_WR = 1'b0;
  logic        ROW_END = 1'b0, DISP_ADV = 1'b0, ROW_START_LD = 1'b0, ADC_EOC;
  logic [7:0]  IO_ADDR = 8'h00, ADC_DATA, IO_RDATA, adc_val = 8'h00;
  logic [3:0]  BAUD_SW = 4'ha;
  logic [11:0] ROW_START_VAL = 12'h000, DISP_ADDR, exp_addr = 12'h000, pend_val;
  logic        IO_RVALID, SCE_SEL, SCE_RD, SCE_WR, BAUD_SEL, ADC_SEL, ADC_CLK;
  logic        ADC_START, ADC_ALE, ADC_OE, ADC_IRQ, ADC_BUSY, pend = 1'b0;
  logic [2:0]  SCE_REG, ADC_CHAN;
  logic [15:0] ADC_IRQ_VECTOR;
  int          err_count = 0, checks = 0, seed = 32'h586b91c7;

  tpio_decode i_tpio_decode (.REF_CLK, .SYS_RST, .IO_ADDR, .IO_RD, .IO_WR, .IO_RDATA,
    .IO_RVALID, .SCE_SEL, .SCE_REG, .SCE_RD, .SCE_WR, .BAUD_SEL, .BAUD_SW, .ADC_SEL,
    .ADC_CLK, .ADC_START, .ADC_ALE, .ADC_CHAN, .ADC_OE, .ADC_EOC, .ADC_DATA, .ADC_IRQ,
    .ADC_IRQ_VECTOR, .ADC_BUSY, .ROW_END, .DISP_ADV, .ROW_START_LD, .ROW_START_VAL,
    .DISP_ADDR);
  tpio_adc_model i_tpio_adc_model (.clk(REF_CLK), .start(ADC_START), .oe(ADC_OE),
    .val(adc_val), .eoc(ADC_EOC), .data(ADC_DATA));

  initial forever #5 REF_CLK = ~REF_CLK;
  // =====================================================================
  // Helpers
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic io(input logic rd, input logic [7:0] a);
    @(posedge REF_CLK);
    IO_RD <= rd;
    IO_WR <= !rd;
    IO_ADDR <= a;
    @(posedge REF_CLK);
    IO_RD <= 1'b0;
    IO_WR <= 1'b0;
    #1;
  endtask
  function automatic logic [2:0] exp_sel(input logic [7:0] a);
    return {a >= 8'h20 && a <= 8'h26, a == 8'h28, a[7:3] == 5'h06};
  endfunction
  initial begin
    #200000;
    err_count++;
    end_of_test;
  end
  // =====================================================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic        rd;
    logic [2:0]  e;
    time         t0;
    repeat (20) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    r = $random(seed);
    BAUD_SW <= r[3:0];
    repeat (3) @(posedge REF_CLK);
    for (int i = 0; i < 256; i++) begin
      r = $random(seed);
      rd = r[0] | (i[7:4] == 4'h3);
      e = exp_sel(i[7:0]);
      io(rd, i[7:0]);
      chk({SCE_SEL, BAUD_SEL, ADC_SEL}, e);
      chk({SCE_RD, SCE_WR}, {e[2] & rd, e[2] & !rd});
      if (e[2]) chk(SCE_REG, i[2:0]);
      if (e[1] && rd) chk(IO_RDATA, BAUD_SW);
    end
    @(posedge ADC_CLK);
    t0 = $time;
    @(posedge ADC_CLK);
    chk(16'(($time - t0) / 64'ha), 16'h0080);
    for (int n = 0; n < 8; n++) begin
      r = $random(seed);
      adc_val <= r[7:0];
      io(1'b0, 8'h30 + n);
      chk({ADC_START, ADC_ALE, ADC_BUSY, ADC_CHAN}, {3'h7, n[2:0]});
      io(1'b0, 8'h37 - n);
      chk({ADC_SEL, ADC_CHAN}, {1'b1, n[2:0]});
      for (int t = 0; t < 1000 && ADC_IRQ !== 1'b1; t++) @(posedge REF_CLK);
      chk({ADC_IRQ, ADC_OE, ADC_BUSY}, 3'h6);
      chk(ADC_IRQ_VECTOR, 16'h0030);
      io(1'b1, {5'h06, r[10:8]});
      chk(IO_RDATA, adc_val);
      chk(ADC_IRQ, 1'b0);
    end
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      @(posedge REF_CLK);
      ROW_END <= r[0];
      DISP_ADV <= r[1];
      ROW_START_LD <= r[2] & r[3];
      ROW_START_VAL <= r[15:4];
      @(posedge REF_CLK);
      ROW_END <= 1'b0;
      DISP_ADV <= 1'b0;
      ROW_START_LD <= 1'b0;
      if (r[0]) begin
        exp_addr = pend ? pend_val : exp_addr + 12'h001;
        pend = 1'b0;
      end else if (r[1]) exp_addr = exp_addr + 12'h001;
      if (r[2] & r[3]) begin
        pend = 1'b1;
        pend_val = r[15:4];
      end
      #1 chk(DISP_ADDR, exp_addr);
    end
    end_of_test;
  end
endmodule // tpio_decode_test
